//--- hmio_consts.vh
/*
 parameter addresses, factory values, codes and state encodings for the
 homing and local pin configuration block. included by both design files.
*/
`ifndef HMIO_CONSTS_VH
`define HMIO_CONSTS_VH
`define HMIO_ADR_ENMODE 16'h050C
`define HMIO_ADR_PIN1 16'h0722
`define HMIO_ADR_PIN2 16'h0724
`define HMIO_ADR_PIN3 16'h0726
`define HMIO_ADR_DOUT 16'h0822
`define HMIO_ADR_PRESET 16'h1B2C
`define HMIO_ADR_SRCH_SPD 16'h2808
`define HMIO_ADR_LEAVE_SPD 16'h280A
`define HMIO_ADR_PT_DIST 16'h280C
`define HMIO_ADR_HOME_POS 16'h2816
`define HMIO_ADR_OT_DIST 16'h281A
`define HMIO_RST_SRCH_SPD 16'h003C
`define HMIO_RST_LEAVE_SPD 16'h0006
`define HMIO_RST_PIN_FUNC 16'h0001
`define HMIO_SPD_MIN 16'h0001
`define HMIO_SPD_MAX 16'h0BB8
`define HMIO_ENMODE_EDGE 16'h0000
`define HMIO_ENMODE_LEVEL 16'h0001
`define HMIO_ENMODE_AUTO 16'h0002
`define HMIO_F_FREE 16'h0001
`define HMIO_F_FRST 16'h0002
`define HMIO_F_EN 16'h0003
`define HMIO_F_HALT 16'h0004
`define HMIO_F_JOGP 16'h0009
`define HMIO_F_JOGN 16'h000A
`define HMIO_F_JOGFS 16'h000B
`define HMIO_F_REF 16'h0014
`define HMIO_F_POS_END 16'h0015
`define HMIO_F_NEG_END 16'h0016
`define HMIO_F_OFREE 16'h0065
`define HMIO_F_ONOFLT 16'h0066
`define HMIO_F_ORDY 16'h0067
`define HMIO_METHOD_PRESET 8'h23
`define HMIO_ST_IDLE 3'h0
`define HMIO_ST_SEEK 3'h1
`define HMIO_ST_POINT 3'h2
`define HMIO_ST_RETURN 3'h3
`define HMIO_ST_DONE 3'h4
`define HMIO_ST_FAIL 3'h5
`endif

//--- hmio_motion_model.sv
/*
 motion core and switch model: reports switch found, switching point
 and travel while homing runs. assumes busy comes from hmio_top.
*/
`timescale 1ns/1ps
`default_nettype none
module hmio_motion_model #(
  parameter SEEK_CYC = 8'h1E
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic busy_i,
  input wire logic miss_i,
  output wire logic seen_o,
  output wire logic point_o,
  output wire logic lost_o,
  output logic [31:0] travel_o
);
  logic [7:0] cnt;
  // travel restarts at homing start and when the switch is seen, grows 10 units a cycle
  always @(posedge clk_i) begin
    if (!rst_n_i || !busy_i) begin
      cnt <= 8'h00;
      travel_o <= 32'h0;
    end else begin
      cnt <= cnt + 8'h01;
      travel_o <= (cnt == SEEK_CYC) ? 32'h0 : travel_o + 32'hA;
    end
  end
  // single-cycle switch events; miss drops the overrun switch early and hides the point
  assign seen_o = busy_i && cnt == SEEK_CYC;
  assign point_o = busy_i && !miss_i && cnt == SEEK_CYC + 8'h08;
  assign lost_o = busy_i && miss_i && cnt == 8'h05;
endmodule // hmio_motion_model
`default_nettype wire

//--- hmio_pin.v
/*
 one local i/o pin: decodes its latched function code into input roles
 and output drive. assumes the pin input is already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hmio_consts.vh"
module hmio_pin (
  input wire clk_i,
  input wire rst_n_i,
  input wire [15:0] func_i,
  input wire pin_in_i,
  input wire dout_bit_i,
  input wire no_fault_i,
  input wire ready_i,
  output reg pin_o,
  output reg pin_oe_o,
  output reg [8:0] role_o
);
  // role bits: frst en halt jogp jogn jogfs ref pos_end neg_end
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
      role_o <= 9'h000;
    end else begin
      pin_oe_o <= (func_i == `HMIO_F_OFREE) || (func_i == `HMIO_F_ONOFLT) ||
                  (func_i == `HMIO_F_ORDY); // see R14
      pin_o <= (func_i == `HMIO_F_OFREE) ? dout_bit_i :
               (func_i == `HMIO_F_ONOFLT) ? no_fault_i :
               (func_i == `HMIO_F_ORDY) ? ready_i : 1'b0;
      role_o <= {func_i == `HMIO_F_FRST, func_i == `HMIO_F_EN, func_i == `HMIO_F_HALT,
                 func_i == `HMIO_F_JOGP, func_i == `HMIO_F_JOGN, func_i == `HMIO_F_JOGFS,
                 func_i == `HMIO_F_REF, func_i == `HMIO_F_POS_END,
                 func_i == `HMIO_F_NEG_END} & {9{pin_in_i}}; // see R11
    end
  end
endmodule // hmio_pin
`default_nettype wire

//--- hmio_top.v
/*
 homing parameter set, homing sequencer and local pin configuration.
 parameters arrive as single-cycle writes/reads at their fieldbus address
 from the fieldbus engine on the same clock; motion and position come from
 the motion core on the same clock, as do the switch events; pins are asynchronous.
*/
// How it works
// R1: the switch search speed (1..3000, default 60) is the seek target, capped by the ceiling.
// R2: the leave speed (default 6) is the target when moving off a switch, capped likewise.
// R3: homing speeds and distances are snapshotted when a movement starts.
// R4: a nonzero switching point distance aborts homing with an error when exceeded; 0 disables.
// R5: on homing success the home position value is loaded as actual position.
// R6: method 35 sets position to the preset value, and preset writes act at once; the code loads them only with method 35 selected and home_busy_o high in idle.
// R7: a nonzero overtravel distance cancels homing if the switch does not return in time.
// R8: enable mode 0 needs a rising enable edge, 1 an enable level, 2 enables automatically.
// R9: a new enable mode is used only from the next power stage enabling.
// R10: each direct output bit drives one digital output, bit 0 the first.
// R11: pin selectors accept input codes 1,2,3,4,9,10,11,20.
// R12: fault reset and enable pin functions act only in local control mode.
// R13: only pin 1 takes code 21 and only pin 2 takes code 22.
// R14: codes 101,102,103 make a pin an output.
// R15: selector writes are accepted only while the power stage is disabled.
// R16: a new pin function takes effect only after the next power-on.
// R17: writes outside a parameter's range or code list are rejected, value kept.
`timescale 1ns/1ps
`default_nettype none
`include "hmio_consts.vh"
module hmio_top #(
  parameter NUM_DOUT = 3,
  parameter NUM_PIN = 3
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire poweron_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] addr_i,
  input wire [31:0] wdata_i,
  output reg [31:0] rdata_o,
  output reg ack_o,
  output reg err_o,
  input wire [15:0] velocity_ceiling_i,
  input wire local_mode_i,
  input wire no_fault_i,
  input wire ready_i,
  input wire home_start_i,
  input wire [7:0] home_method_i,
  input wire switch_seen_i,
  input wire switch_point_i,
  input wire switch_lost_i,
  input wire [31:0] travel_i,
  input wire disable_req_i,
  input wire [NUM_PIN-1:0] pin_i,
  output reg [NUM_PIN-1:0] pin_o,
  output reg [NUM_PIN-1:0] pin_oe_o,
  output reg [NUM_DOUT-1:0] dout_o,
  output reg stage_en_o,
  output reg [15:0] target_speed_o,
  output reg pos_load_o,
  output reg [31:0] pos_value_o,
  output reg home_busy_o,
  output reg home_err_o,
  output reg fault_reset_o,
  output reg halt_o,
  output reg [2:0] jog_o,
  output reg ref_switch_o,
  output reg positive_end_switch_o,
  output reg negative_end_switch_o
);
  reg [15:0] poweron_stage_enable_mode;
  reg [15:0] pin_func [0:NUM_PIN-1];
  reg [15:0] pin_live [0:NUM_PIN-1];
  reg [15:0] direct_output_bits;
  reg [31:0] preset_position_value;
  reg [15:0] switch_search_speed;
  reg [15:0] switch_leave_speed;
  reg [31:0] switch_point_max_dist;
  reg [31:0] home_position_value;
  reg [31:0] overtravel_search_dist;
  reg [15:0] snap_srch;
  reg [15:0] snap_leave;
  reg [31:0] snap_pt;
  reg [31:0] snap_ot;
  reg [31:0] snap_home;
  reg [15:0] en_mode_live;
  reg [2:0] state;
  reg [NUM_PIN-1:0] pin_s1;
  reg [NUM_PIN-1:0] pin_s2;
  reg en_prev;
  reg [15:0] next_rd16;
  reg [31:0] next_rd;
  wire [8:0] role [0:NUM_PIN-1];
  reg [8:0] role_any;
  wire [NUM_PIN-1:0] pin_en_w;
  wire [NUM_PIN-1:0] pin_drv_w;
  wire [1:0] sel_idx;
  integer kw;
  integer kl;
  integer kr;

  // selector index from the address; only read for selector addresses
  assign sel_idx = (addr_i == `HMIO_ADR_PIN1) ? 2'h0 :
                   (addr_i == `HMIO_ADR_PIN2) ? 2'h1 : 2'h2;

  // pin synchronisers, first stage read only by the second
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_s1 <= {NUM_PIN{1'b0}};
      pin_s2 <= {NUM_PIN{1'b0}};
    end else begin
      pin_s1 <= pin_i;
      pin_s2 <= pin_s1;
    end
  end

  // selector code check, per pin because limit codes are pin-specific
  function func_ok;
    input [15:0] v;
    input [1:0] idx;
    begin
      func_ok = (v == `HMIO_F_FREE) || (v == `HMIO_F_FRST) || (v == `HMIO_F_EN) ||
                (v == `HMIO_F_HALT) || (v == `HMIO_F_JOGP) || (v == `HMIO_F_JOGN) ||
                (v == `HMIO_F_JOGFS) || (v == `HMIO_F_REF) ||
                (v == `HMIO_F_OFREE) || (v == `HMIO_F_ONOFLT) ||
                (v == `HMIO_F_ORDY) || // see R11 // see R14
                ((idx == 2'h0) && (v == `HMIO_F_POS_END)) ||
                ((idx == 2'h1) && (v == `HMIO_F_NEG_END)); // see R13
    end
  endfunction

  function spd_ok;
    input [31:0] v;
    begin
      spd_ok = (v[31:16] == 16'h0000) && (v[15:0] >= `HMIO_SPD_MIN) &&
               (v[15:0] <= `HMIO_SPD_MAX);
    end
  endfunction

  // read mux
  always @* begin
    next_rd16 = 16'h0000;
    next_rd = 32'h0000_0000;
    case (addr_i)
      `HMIO_ADR_ENMODE: next_rd16 = poweron_stage_enable_mode;
      `HMIO_ADR_PIN1: next_rd16 = pin_func[0];
      `HMIO_ADR_PIN2: next_rd16 = pin_func[1];
      `HMIO_ADR_PIN3: next_rd16 = pin_func[2];
      `HMIO_ADR_DOUT: next_rd16 = direct_output_bits;
      `HMIO_ADR_SRCH_SPD: next_rd16 = switch_search_speed;
      `HMIO_ADR_LEAVE_SPD: next_rd16 = switch_leave_speed;
      `HMIO_ADR_PRESET: next_rd = preset_position_value;
      `HMIO_ADR_PT_DIST: next_rd = switch_point_max_dist;
      `HMIO_ADR_HOME_POS: next_rd = home_position_value;
      `HMIO_ADR_OT_DIST: next_rd = overtravel_search_dist;
      default: next_rd = 32'h0000_0000;
    endcase
    if (next_rd16 != 16'h0000) begin
      next_rd = {16'h0000, next_rd16};
    end
  end

  // parameter writes with range checks; ack on every access, err on rejection
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      poweron_stage_enable_mode <= `HMIO_ENMODE_EDGE;
      for (kw = 0; kw < NUM_PIN; kw = kw + 1) begin
        pin_func[kw] <= `HMIO_RST_PIN_FUNC;
      end
      direct_output_bits <= 16'h0000;
      preset_position_value <= 32'h0000_0000;
      switch_search_speed <= `HMIO_RST_SRCH_SPD;
      switch_leave_speed <= `HMIO_RST_LEAVE_SPD;
      switch_point_max_dist <= 32'h0000_0000;
      home_position_value <= 32'h0000_0000;
      overtravel_search_dist <= 32'h0000_0000;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else begin
      ack_o <= wr_i | rd_i;
      err_o <= 1'b0;
      if (rd_i) begin
        rdata_o <= next_rd;
      end
      if (wr_i) begin
        case (addr_i)
          `HMIO_ADR_ENMODE:
            if (wdata_i <= {16'h0000, `HMIO_ENMODE_AUTO}) poweron_stage_enable_mode <= wdata_i[15:0];
            else err_o <= 1'b1; // see R17
          `HMIO_ADR_PIN1, `HMIO_ADR_PIN2, `HMIO_ADR_PIN3: begin
            if (!stage_en_o && wdata_i[31:16] == 16'h0000 && func_ok(wdata_i[15:0], sel_idx))
              pin_func[sel_idx] <= wdata_i[15:0]; // see R15 // see R17
            else err_o <= 1'b1;
          end
          `HMIO_ADR_DOUT: direct_output_bits <= wdata_i[15:0];
          `HMIO_ADR_PRESET: preset_position_value <= wdata_i;
          `HMIO_ADR_SRCH_SPD:
            if (spd_ok(wdata_i)) switch_search_speed <= wdata_i[15:0];
            else err_o <= 1'b1; // see R17
          `HMIO_ADR_LEAVE_SPD:
            if (spd_ok(wdata_i)) switch_leave_speed <= wdata_i[15:0];
            else err_o <= 1'b1; // see R17
          `HMIO_ADR_PT_DIST:
            if (!wdata_i[31]) switch_point_max_dist <= wdata_i;
            else err_o <= 1'b1; // see R17
          `HMIO_ADR_HOME_POS: home_position_value <= wdata_i;
          `HMIO_ADR_OT_DIST:
            if (!wdata_i[31]) overtravel_search_dist <= wdata_i;
            else err_o <= 1'b1; // see R17
          default: err_o <= 1'b1;
        endcase
      end
    end
  end

  // live pin functions copied only on the power-on pulse
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (kl = 0; kl < NUM_PIN; kl = kl + 1) begin
        pin_live[kl] <= `HMIO_RST_PIN_FUNC;
      end
    end else if (poweron_i) begin
      for (kl = 0; kl < NUM_PIN; kl = kl + 1) begin
        pin_live[kl] <= pin_func[kl]; // see R16
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PIN; g = g + 1) begin : g_pin
      hmio_pin hmio_pin_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .func_i(pin_live[g]),
        .pin_in_i(pin_s2[g]),
        .dout_bit_i(direct_output_bits[g]),
        .no_fault_i(no_fault_i),
        .ready_i(ready_i),
        .pin_o(pin_drv_w[g]),
        .pin_oe_o(pin_en_w[g]),
        .role_o(role[g])
      );
    end
  endgenerate

  // merge pin roles; any pin may carry any input function but the limit codes 21 and 22
  always @* begin
    role_any = 9'h000;
    for (kr = 0; kr < NUM_PIN; kr = kr + 1) begin
      role_any = role_any | role[kr];
    end
  end

  // local role outputs and direct outputs
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_reset_o <= 1'b0;
      halt_o <= 1'b0;
      jog_o <= 3'h0;
      ref_switch_o <= 1'b0;
      positive_end_switch_o <= 1'b0;
      negative_end_switch_o <= 1'b0;
      dout_o <= {NUM_DOUT{1'b0}};
      pin_o <= {NUM_PIN{1'b0}};
      pin_oe_o <= {NUM_PIN{1'b0}};
    end else begin
      fault_reset_o <= role_any[8] & local_mode_i; // see R12
      halt_o <= role_any[6];
      jog_o <= role_any[5:3];
      ref_switch_o <= role_any[2];
      positive_end_switch_o <= role_any[1];
      negative_end_switch_o <= role_any[0];
      dout_o <= direct_output_bits[NUM_DOUT-1:0]; // see R10
      pin_oe_o <= pin_en_w; // see R14
      pin_o <= pin_drv_w; // see R10
    end
  end

  // power stage enable; mode latched at each disable request
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      stage_en_o <= 1'b0;
      en_prev <= 1'b0;
      en_mode_live <= `HMIO_ENMODE_EDGE;
    end else begin
      en_prev <= role_any[7] & local_mode_i; // see R12
      if (disable_req_i) begin
        stage_en_o <= 1'b0;
        en_mode_live <= poweron_stage_enable_mode; // see R9
      end else if (!stage_en_o) begin
        case (en_mode_live)
          `HMIO_ENMODE_EDGE: stage_en_o <= role_any[7] & local_mode_i & ~en_prev; // see R8
          `HMIO_ENMODE_LEVEL: stage_en_o <= role_any[7] & local_mode_i; // see R8
          `HMIO_ENMODE_AUTO: stage_en_o <= 1'b1; // see R8
          default: stage_en_o <= 1'b0;
        endcase
      end
    end
  end

  // homing sequencer: seek, find point, return on overtravel
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= `HMIO_ST_IDLE;
      snap_srch <= `HMIO_RST_SRCH_SPD;
      snap_leave <= `HMIO_RST_LEAVE_SPD;
      snap_pt <= 32'h0000_0000;
      snap_ot <= 32'h0000_0000;
      snap_home <= 32'h0000_0000;
      target_speed_o <= 16'h0000;
      pos_load_o <= 1'b0;
      pos_value_o <= 32'h0000_0000;
      home_busy_o <= 1'b0;
      home_err_o <= 1'b0;
    end else begin
      pos_load_o <= 1'b0;
      if (wr_i && addr_i == `HMIO_ADR_PRESET && home_method_i == `HMIO_METHOD_PRESET &&
          state == `HMIO_ST_IDLE && home_busy_o) begin
        pos_load_o <= 1'b1;
        pos_value_o <= wdata_i; // see R6
      end
      case (state)
        `HMIO_ST_IDLE: begin
          target_speed_o <= 16'h0000;
          if (home_start_i && home_method_i == `HMIO_METHOD_PRESET) begin
            pos_load_o <= 1'b1;
            pos_value_o <= preset_position_value; // see R6
            home_busy_o <= 1'b1;
          end else if (home_start_i) begin
            snap_srch <= switch_search_speed; // see R3
            snap_leave <= switch_leave_speed;
            snap_pt <= switch_point_max_dist;
            snap_ot <= overtravel_search_dist;
            snap_home <= home_position_value;
            home_busy_o <= 1'b1;
            home_err_o <= 1'b0;
            state <= `HMIO_ST_SEEK;
          end else begin
            home_busy_o <= 1'b0;
          end
        end
        `HMIO_ST_SEEK: begin
          target_speed_o <= (snap_srch > velocity_ceiling_i) ? velocity_ceiling_i : snap_srch; // see R1
          if (switch_lost_i) state <= `HMIO_ST_RETURN;
          else if (switch_seen_i) state <= `HMIO_ST_POINT;
        end
        `HMIO_ST_POINT: begin
          target_speed_o <= (snap_leave > velocity_ceiling_i) ? velocity_ceiling_i : snap_leave; // see R2
          if (switch_point_i) state <= `HMIO_ST_DONE;
          else if (snap_pt != 32'h0000_0000 && travel_i > snap_pt) state <= `HMIO_ST_FAIL; // see R4
        end
        `HMIO_ST_RETURN: begin
          target_speed_o <= (snap_srch > velocity_ceiling_i) ? velocity_ceiling_i : snap_srch;
          if (switch_seen_i) state <= `HMIO_ST_POINT;
          else if (snap_ot != 32'h0000_0000 && travel_i > snap_ot) state <= `HMIO_ST_FAIL; // see R7
        end
        `HMIO_ST_DONE: begin
          pos_load_o <= 1'b1;
          pos_value_o <= snap_home; // see R5
          target_speed_o <= 16'h0000;
          state <= `HMIO_ST_IDLE;
        end
        `HMIO_ST_FAIL: begin
          home_err_o <= 1'b1;
          target_speed_o <= 16'h0000;
          state <= `HMIO_ST_IDLE;
        end
        default: state <= `HMIO_ST_IDLE;
      endcase
    end
  end
endmodule // hmio_top
`default_nettype wire

//--- hmio_top_assertions.sv
/*
 concurrent checks on the ports of hmio_top, attached by bind.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hmio_consts.vh"
module hmio_checker #(
  parameter NUM_DOUT = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] rdata_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [15:0] velocity_ceiling_i,
  input wire logic home_start_i,
  input wire logic [7:0] home_method_i,
  input wire logic [NUM_DOUT-1:0] dout_o,
  input wire logic stage_en_o,
  input wire logic [15:0] target_speed_o,
  input wire logic pos_load_o,
  input wire logic home_busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [NUM_DOUT-1:0] exp_dout;
  // shadow of the direct output word; dout lags it by one edge
  always @(posedge clk_i) begin
    if (!rst_n_i) exp_dout <= '0;
    else if (wr_i && addr_i == `HMIO_ADR_DOUT) exp_dout <= wdata_i[NUM_DOUT-1:0];
  end
  a_ack_follows: assert property ((wr_i || rd_i) |=> ack_o)
    else $error("no ack after request");
  a_ack_caused: assert property (ack_o |-> $past(wr_i || rd_i))
    else $error("ack without request");
  a_err_with_ack: assert property (err_o |-> ack_o)
    else $error("err outside ack");
  a_selector_locked: assert property (wr_i && stage_en_o && (addr_i == `HMIO_ADR_PIN1 ||
    addr_i == `HMIO_ADR_PIN2 || addr_i == `HMIO_ADR_PIN3) |=> err_o)
    else $error("selector write taken while enabled");
  a_speed_capped: assert property (home_busy_o |-> target_speed_o <= velocity_ceiling_i
    && target_speed_o <= `HMIO_SPD_MAX) else $error("target speed above ceiling");
  a_dout_follows: assert property ($stable(exp_dout) [*2] |-> dout_o == exp_dout)
    else $error("direct outputs differ from written bits");
  a_load_pulse: assert property (pos_load_o |=> !pos_load_o)
    else $error("position load longer than one cycle");
  a_rdata_holds: assert property (!$past(rd_i) |-> $stable(rdata_o))
    else $error("read data moved without read");
  a_start_busy: assert property (home_start_i && home_method_i != `HMIO_METHOD_PRESET
    |-> ##[1:2] home_busy_o) else $error("homing did not start");
  a_preset_load: assert property (home_start_i && home_method_i == `HMIO_METHOD_PRESET
    |=> pos_load_o) else $error("preset not loaded");
endmodule // hmio_checker
bind hmio_top hmio_checker #(.NUM_DOUT(NUM_DOUT)) hmio_checker_i (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .ack_o(ack_o), .err_o(err_o), .velocity_ceiling_i(velocity_ceiling_i),
  .home_start_i(home_start_i), .home_method_i(home_method_i), .dout_o(dout_o),
  .stage_en_o(stage_en_o), .target_speed_o(target_speed_o), .pos_load_o(pos_load_o),
  .home_busy_o(home_busy_o));
`default_nettype wire

//--- homing_and_local_io_config_tb.sv
/*
 self-checking bench for hmio_top: parameter access, pin functions,
 stage enable and homing. assumes hmio_motion_model on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hmio_consts.vh"
module homing_and_local_io_config_tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, poweron_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [15:0] addr_i = 16'h0, ceil_i = 16'h0BB8;
  logic [31:0] wdata_i = 32'h0;
  logic local_mode_i = 1'b0, home_start_i = 1'b0, disable_req_i = 1'b0, miss = 1'b0;
  logic [7:0] method = 8'h11;
  logic [2:0] pin_drv = 3'b000;
  logic [31:0] codes [11] = '{1, 2, 3, 4, 9, 10, 11, 20, 101, 102, 103};
  wire [31:0] rdata_o, travel, pos_value_o;
  wire ack_o, err_o, stage_en_o, pos_load_o, home_busy_o, home_err_o, halt_o;
  wire seen, point, lost;
  wire [2:0] pin_o, pin_oe_o, dout_o, pin_w;
  wire [15:0] target_speed_o;
  int n_fail = 0, comparisons = 0, cyc = 0, i;
  // pin wire level: driven pins show the block's value
  assign pin_w = (pin_oe_o & pin_o) | (~pin_oe_o & pin_drv);
  hmio_top hmio_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .poweron_i(poweron_i), .wr_i(wr_i),
    .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ack_o(ack_o),
    .err_o(err_o), .velocity_ceiling_i(ceil_i), .local_mode_i(local_mode_i),
    .no_fault_i(1'b1), .ready_i(1'b1), .home_start_i(home_start_i), .home_method_i(method),
    .switch_seen_i(seen), .switch_point_i(point), .switch_lost_i(lost), .travel_i(travel),
    .disable_req_i(disable_req_i), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .dout_o(dout_o), .stage_en_o(stage_en_o), .target_speed_o(target_speed_o),
    .pos_load_o(pos_load_o), .pos_value_o(pos_value_o), .home_busy_o(home_busy_o),
    .home_err_o(home_err_o), .fault_reset_o(), .halt_o(halt_o), .jog_o(), .ref_switch_o(),
    .positive_end_switch_o(), .negative_end_switch_o());
  hmio_motion_model hmio_motion_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .busy_i(home_busy_o), .miss_i(miss), .seen_o(seen), .point_o(point), .lost_o(lost),
    .travel_o(travel));
  // 200 MHz clock and a hang limit well above the expected run
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one access; for reads d is the expected data, e the expected error
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e);
    @(negedge clk_i);
    wr_i = w;
    rd_i = !w;
    addr_i = a;
    wdata_i = d;
    @(negedge clk_i);
    wr_i = 1'b0;
    rd_i = 1'b0;
    chk({30'h0, ack_o, err_o}, {30'h0, 1'b1, e});
    if (!w) chk(rdata_o, d);
  endtask
  task automatic start;
    @(negedge clk_i);
    home_start_i = 1'b1;
    @(negedge clk_i);
    home_start_i = 1'b0;
  endtask
  task automatic t_defaults;
    acc(0, `HMIO_ADR_SRCH_SPD, 32'h3C, 0);
    acc(0, `HMIO_ADR_LEAVE_SPD, 32'h6, 0);
    acc(0, `HMIO_ADR_ENMODE, 32'h0, 0);
    acc(0, `HMIO_ADR_PT_DIST, 32'h0, 0);
    acc(0, `HMIO_ADR_OT_DIST, 32'h0, 0);
    acc(0, `HMIO_ADR_HOME_POS, 32'h0, 0);
    acc(0, `HMIO_ADR_PIN1, 32'h1, 0);
    acc(0, 16'h0100, 32'h0, 0);
  endtask
  task automatic t_ranges;
    acc(1, `HMIO_ADR_SRCH_SPD, 32'h0, 1);
    acc(1, `HMIO_ADR_SRCH_SPD, 32'hBB9, 1);
    acc(1, `HMIO_ADR_SRCH_SPD, 32'hBB8, 0);
    acc(0, `HMIO_ADR_SRCH_SPD, 32'hBB8, 0);
    acc(1, `HMIO_ADR_ENMODE, 32'h3, 1);
    acc(1, `HMIO_ADR_PIN3, 32'h15, 1);
    acc(1, `HMIO_ADR_PIN2, 32'h15, 1);
    acc(1, `HMIO_ADR_PIN1, 32'h16, 1);
    acc(1, `HMIO_ADR_PIN1, 32'h15, 0);
    acc(1, `HMIO_ADR_PIN2, 32'h16, 0);
    acc(1, `HMIO_ADR_PIN3, 32'h5, 1);
    acc(1, `HMIO_ADR_PIN3, 32'h68, 1);
    acc(0, `HMIO_ADR_PIN3, 32'h1, 0);
    foreach (codes[k]) begin
      acc(1, `HMIO_ADR_PIN3, codes[k], 0);
      acc(0, `HMIO_ADR_PIN3, codes[k], 0);
    end
    acc(1, 16'h0100, 32'h1, 1);
  endtask
  task automatic t_pins;
    acc(1, `HMIO_ADR_DOUT, 32'h5, 0);
    repeat (2) @(negedge clk_i);
    chk(32'(dout_o), 32'h5);
    acc(1, `HMIO_ADR_PIN1, 32'h65, 0);
    acc(1, `HMIO_ADR_PIN2, 32'h3, 0);
    acc(1, `HMIO_ADR_PIN3, 32'h4, 0);
    pin_drv = 3'b100;
    repeat (5) @(negedge clk_i);
    chk({pin_oe_o, halt_o}, 4'h0);
    poweron_i = 1'b1;
    @(negedge clk_i);
    poweron_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk({pin_oe_o, halt_o}, 4'h3);
    chk(32'(pin_o & pin_oe_o), 32'h1);
    pin_drv = 3'b000;
  endtask
  task automatic t_enable;
    pin_drv[1] = 1'b1;
    acc(1, `HMIO_ADR_ENMODE, 32'h2, 0);
    repeat (8) @(negedge clk_i);
    chk(32'(stage_en_o), 32'h0);
    pin_drv[1] = 1'b0;
    repeat (4) @(negedge clk_i);
    local_mode_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(32'(stage_en_o), 32'h0);
    pin_drv[1] = 1'b1;
    for (i = 0; i < 10 && stage_en_o !== 1'b1; i++) @(negedge clk_i);
    chk(32'(stage_en_o), 32'h1);
    acc(1, `HMIO_ADR_PIN3, 32'h1, 1);
    disable_req_i = 1'b1;
    pin_drv[1] = 1'b0;
    for (i = 0; i < 10 && stage_en_o !== 1'b0; i++) @(negedge clk_i);
    disable_req_i = 1'b0;
    for (i = 0; i < 10 && stage_en_o !== 1'b1; i++) @(negedge clk_i);
    chk(32'(stage_en_o), 32'h1);
    acc(1, `HMIO_ADR_ENMODE, 32'h1, 0);
    pin_drv[1] = 1'b1;
    disable_req_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(32'(stage_en_o), 32'h0);
    disable_req_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(32'(stage_en_o), 32'h1);
    pin_drv[1] = 1'b0;
  endtask
  task automatic t_home;
    acc(1, `HMIO_ADR_HOME_POS, 32'h1234_5678, 0);
    acc(1, `HMIO_ADR_SRCH_SPD, 32'h64, 0);
    ceil_i = 16'h5A;
    start();
    for (i = 0; i < 10 && target_speed_o !== 16'h5A; i++) @(negedge clk_i);
    chk(32'(target_speed_o), 32'h5A);
    acc(1, `HMIO_ADR_SRCH_SPD, 32'h46, 0);
    @(negedge clk_i);
    chk(32'(target_speed_o), 32'h5A);
    for (i = 0; i < 40 && target_speed_o !== 16'h6; i++) @(negedge clk_i);
    chk(32'(target_speed_o), 32'h6);
    for (i = 0; i < 20 && pos_load_o !== 1'b1; i++) @(negedge clk_i);
    chk(pos_value_o, 32'h1234_5678);
    repeat (4) @(negedge clk_i);
    ceil_i = 16'h0BB8;
  endtask
  task automatic t_abort;
    acc(1, `HMIO_ADR_PT_DIST, 32'h32, 0);
    miss = 1'b1;
    start();
    for (i = 0; i < 80 && home_err_o !== 1'b1; i++) @(negedge clk_i);
    chk(32'(home_err_o), 32'h1);
    miss = 1'b0;
  endtask
  // overrun switch drops early; only the overtravel limit can fail this fast
  task automatic t_overtravel;
    acc(1, `HMIO_ADR_OT_DIST, 32'h14, 0);
    miss = 1'b1;
    start();
    for (i = 0; i < 12 && home_err_o !== 1'b1; i++) @(negedge clk_i);
    chk(32'(home_err_o), 32'h1);
    miss = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic t_preset;
    method = `HMIO_METHOD_PRESET;
    acc(1, `HMIO_ADR_PRESET, 32'hFFFF_FF00, 0);
    start();
    chk({31'h0, pos_load_o}, 32'h1);
    chk(pos_value_o, 32'hFFFF_FF00);
  endtask
  task automatic results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // reset for six cycles, then the scenarios in order
  initial begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_defaults();
    t_ranges();
    t_pins();
    t_enable();
    t_home();
    t_abort();
    t_overtravel();
    t_preset();
    results();
  end
endmodule // homing_and_local_io_config_tb
`default_nettype wire
